/* File: tmss_pkg.sv */
// How it works
// R1: Scope pin pulses across each enabled key burst.
// R2: Scope enable applies only after reset or recalibration.
// R3: Line lock syncs at lowest enabled key only.
// R4: Only falling sync edges count, rising ignored.
// R5: Sync input must be clean buffered logic.
// R6: Missing sync inserts 100ms wait between scans.
// R7: Sync timeout sets a readable error flag.
// R8: Bursts start on a fixed global slot.
// R9: Slot interval from byte 97 low nibble.
// R10: Reference below floor raises low signal error.
// R11: Floor is bytes 98-99, low byte first.
// R12: Byte 100 holds checksum, device verifies it.
// R13: Setup block accepted only after two 0x01 commands.
// R14: Setup block is always 101 bytes, 24 keys.
// R15: Threshold is nibble plus four, drift via table.
// R16: Slow confirm zero disables key, quick confirm upper.
// R17: Recal delay bytes from 48, 255 illegal.
// R18: Byte 72 group: pulses, suppression, scope enable.
// R19: Byte 96 bit 6 enables line lock.
// R20: Key reports: byte per Y line, bit X.
// R21: Disabled keys take no slot in scans.
// R22: Host and device share one checksum algorithm.
package tmss_pkg;

	// ****************************************
	// Setup block layout.
	// ****************************************
	localparam int NUM_KEYS      = 24;
	localparam int SETUP_LEN     = 101;
	localparam int CFG_LEN       = 100;
	localparam int OFS_THR_DRIFT = 32'h00;
	localparam int OFS_CONFIRM   = 32'h18;
	localparam int OFS_RECAL     = 32'h30;
	localparam int OFS_PULSE     = 32'h48;
	localparam int OFS_LINE_LOCK = 32'h60;
	localparam int OFS_SLOT      = 32'h61;
	localparam int OFS_FLOOR     = 32'h62;
	localparam int OFS_CHECKSUM  = 32'h64;

	// Field positions and limits.
	localparam int LINE_LOCK_BIT = 6;
	localparam int SUPPRESS_BIT  = 6;
	localparam int SCOPE_BIT     = 7;
	localparam int THR_OFFSET    = 4;
	localparam int SLOT_MIN      = 1;
	localparam int SLOT_MAX      = 11;
	localparam int FLOOR_MAX     = 2047;
	localparam logic [7:0] RECAL_ILLEGAL = 8'hff;
	localparam logic [7:0] CMD_SETUP     = 8'h01;

	// Reset values of the setup bytes.
	localparam logic [7:0]  RST_THR_DRIFT = 8'ha6;
	localparam logic [7:0]  RST_CONFIRM   = 8'h52;
	localparam logic [7:0]  RST_RECAL     = 8'h14;
	localparam logic [7:0]  RST_PULSE     = 8'h20;
	localparam logic [7:0]  RST_LINE_LOCK = 8'h00;
	localparam logic [7:0]  RST_SLOT      = 8'h01;
	localparam logic [15:0] RST_FLOOR     = 16'h0064;

	typedef logic [CFG_LEN-1:0][7:0] tmss_cfg_t;
	localparam tmss_cfg_t CFG_RESET = {RST_FLOOR, RST_SLOT, RST_LINE_LOCK, {24{RST_PULSE}},
		{24{RST_RECAL}}, {24{RST_CONFIRM}}, {24{RST_THR_DRIFT}}};

	// ****************************************
	// Timing.
	// ****************************************
	localparam int SYS_CLK_MHZ     = 10;
	localparam int SYS_CLK_HZ      = 10_000_000;
	localparam int SLOT_BASE_NS    = 500_000;
	localparam int SLOT_STEP_NS    = 250_000;
	localparam int SYNC_TIMEOUT_NS = 100_000_000;
	localparam int PULSE_FREQ_HZ   = 226_000;
	localparam int SLOT_BASE_CYC   = SLOT_BASE_NS * SYS_CLK_MHZ / 1000;
	localparam int SLOT_STEP_CYC   = SLOT_STEP_NS * SYS_CLK_MHZ / 1000;
	localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_NS / 1000 * SYS_CLK_MHZ;
	localparam int PULSE_CYC       = SYS_CLK_HZ / PULSE_FREQ_HZ;

	// Lookup tables: pulses per burst, drift time in tenths of a second.
	localparam logic [6:0] PULSE_COUNT [4] = '{7'h10, 7'h20, 7'h30, 7'h40};
	localparam logic [6:0] DRIFT_TENTHS [16] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h08, 7'h0a, 7'h0c,
		7'h0f, 7'h14, 7'h19, 7'h21, 7'h2d, 7'h3c, 7'h4b, 7'h64};

	typedef enum logic {MODE_CMD, MODE_LOAD} tmss_mode_t;
	typedef enum logic [1:0] {SCAN_IDLE, SCAN_BURST, SCAN_SYNC_WAIT} tmss_scan_t;

endpackage

/* File: tmss_top.sv */
`timescale 1ns/1ns

// ****************************************
// Serial receiver on the link clock.
// ****************************************
module tmss_spi_rx (
	// Link pins.
	input  wire logic       spi_sck_i,
	input  wire logic       spi_ss_n_i,
	input  wire logic       spi_mosi_i,
	// Reset.
	input  wire logic       srst_i,
	// Received byte and its event toggle.
	output logic [7:0]      rx_byte_o,
	output logic            rx_tog_o
);
	typedef struct packed {
		logic [6:0] shift;
		logic [7:0] data;
		logic       tog;
	} tmss_rx_t;

	logic [2:0] bit_cnt;
	tmss_rx_t   rx_reg;
	tmss_rx_t   rx_next;

	// The bit counter restarts with every frame, since deselect clears it between frames.
	always_ff @(posedge spi_sck_i or posedge spi_ss_n_i or posedge srst_i) begin
		if (spi_ss_n_i || srst_i) begin
			bit_cnt <= 3'h0;
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
		end
	end

	// Bits arrive MSB first; a whole byte flips the toggle.
	always_comb begin
		rx_next = rx_reg;
		rx_next.shift = {rx_reg.shift[5:0], spi_mosi_i};
		if (bit_cnt == 3'h7) begin
			rx_next.data = {rx_reg.shift, spi_mosi_i};
			rx_next.tog  = ~rx_reg.tog;
		end
	end

	// State register of the link side.
	always_ff @(posedge spi_sck_i or posedge srst_i) begin
		if (srst_i) begin
			rx_reg <= '0;
		end else begin
			rx_reg <= rx_next;
		end
	end

	assign rx_byte_o = rx_reg.data;
	assign rx_tog_o  = rx_reg.tog;
endmodule

// ****************************************
// Setup loader and burst scheduler.
// ****************************************
module tmss_top #(
	parameter int         NUM_KEYS         = tmss_pkg::NUM_KEYS,
	parameter int         CNT_W            = 24,
	parameter int         SLOT_BASE_CYC    = tmss_pkg::SLOT_BASE_CYC,
	parameter int         SLOT_STEP_CYC    = tmss_pkg::SLOT_STEP_CYC,
	parameter int         SYNC_TIMEOUT_CYC = tmss_pkg::SYNC_TIMEOUT_CYC,
	parameter logic [7:0] CRC_POLY         = 8'h07,
	parameter logic [7:0] CRC_INIT         = 8'h00
) (
	// Clock and reset.
	input  wire logic        clk_sys_i,
	input  wire logic        srst_i,
	// Serial slave port.
	input  wire logic        spi_sck_i,
	input  wire logic        spi_ss_n_i,
	input  wire logic        spi_mosi_i,
	// Line lock sync pin.
	input  wire logic        line_sync_i,
	// Acquisition side.
	input  wire logic        ref_valid_i,
	input  wire logic [4:0]  ref_key_i,
	input  wire logic [15:0] ref_level_i,
	input  wire logic [23:0] recal_i,
	input  wire logic [23:0] key_touch_i,
	input  wire logic        sync_err_clear_i,
	// Setup status.
	output logic             setup_mode_o,
	output logic             load_ok_o,
	output logic             load_error_o,
	// Error flags.
	output logic             sync_error_o,
	output logic             low_signal_error_o,
	// Burst control.
	output logic             burst_active_o,
	output logic [4:0]       burst_key_o,
	output logic             scope_trigger_o,
	output logic [6:0]       burst_pulses_o,
	output logic [4:0]       burst_threshold_o,
	output logic [6:0]       burst_drift_tenths_o,
	output logic             burst_suppress_o,
	output logic [3:0]       burst_slow_confirm_o,
	output logic [3:0]       burst_quick_confirm_o,
	output logic [7:0]       burst_recal_delay_o,
	// Key report bytes, one per Y line.
	output logic [7:0]       report_y0_o,
	output logic [7:0]       report_y1_o,
	output logic [7:0]       report_y2_o
);
	localparam logic [CNT_W-1:0] TIMEOUT_LAST = CNT_W'(SYNC_TIMEOUT_CYC - 1);

	typedef struct packed {
		tmss_pkg::tmss_mode_t mode;
		logic                 pend_setup;
		logic [6:0]           idx;
		logic [7:0]           crc;
		logic                 bad;
		tmss_pkg::tmss_cfg_t  shadow;
		tmss_pkg::tmss_cfg_t  cfg;
		logic                 rx_s1;
		logic                 rx_s2;
		logic                 rx_last;
		logic                 ls1;
		logic                 ls2;
		logic                 ls3;
		tmss_pkg::tmss_scan_t scan;
		logic [4:0]           key;
		logic [CNT_W-1:0]     cnt;
		logic [23:0]          scope_live;
		logic [23:0]          low_mask;
		logic                 sync_err;
		logic                 low_err;
		logic                 load_ok;
		logic                 load_err;
		logic                 o_burst;
		logic                 o_scope;
		logic [4:0]           o_key;
		logic [6:0]           o_pulses;
		logic [4:0]           o_thr;
		logic [6:0]           o_drift;
		logic                 o_supp;
		logic [3:0]           o_slow;
		logic [3:0]           o_quick;
		logic [7:0]           o_recal;
		logic [23:0]          o_report;
	} tmss_state_t;

	tmss_state_t      st_reg;
	tmss_state_t      st_next;
	logic [7:0]       rx_byte;
	logic             rx_tog;
	logic             rx_evt;
	logic             sync_fall;
	logic             sync_rise;
	logic [23:0]      en_mask;
	logic [23:0]      scope_cfg;
	logic [4:0]       first_en;
	logic [5:0]       next_en;
	logic             line_lock_en;
	logic [CNT_W-1:0] slot_len;

	tmss_spi_rx u_tmss_spi_rx (
		.spi_sck_i  (spi_sck_i),
		.spi_ss_n_i (spi_ss_n_i),
		.spi_mosi_i (spi_mosi_i),
		.srst_i     (srst_i),
		.rx_byte_o  (rx_byte),
		.rx_tog_o   (rx_tog)
	);

	// One checksum step over a byte, MSB first.
	function automatic logic [7:0] crc8_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[7] ^ d[i]) begin
				r = {r[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				r = {r[6:0], 1'b0};
			end
		end
		return r;
	endfunction

	// Lowest enabled key, and the next enabled key above the current one.
	function automatic logic [4:0] lowest_key(input logic [23:0] m);
		logic [4:0] k;
		k = 5'h00;
		for (int i = NUM_KEYS - 1; i >= 0; i--) begin
			if (m[i]) begin
				k = 5'(i);
			end
		end
		return k;
	endfunction

	function automatic logic [5:0] key_after(input logic [23:0] m, input logic [4:0] cur);
		logic [5:0] r;
		r = 6'h00;
		for (int i = NUM_KEYS - 1; i >= 0; i--) begin
			if (m[i] && i > int'(cur)) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	// Per-key decode of the loaded setup bytes.
	for (genvar k = 0; k < 24; k++) begin : g_key
		assign en_mask[k]   = (k < NUM_KEYS) && (st_reg.cfg[tmss_pkg::OFS_CONFIRM + k][3:0] != 4'h0); // see R16, R21
		assign scope_cfg[k] = st_reg.cfg[tmss_pkg::OFS_PULSE + k][tmss_pkg::SCOPE_BIT]; // see R18
	end

	// Global decode, events and scan order.
	assign line_lock_en = st_reg.cfg[tmss_pkg::OFS_LINE_LOCK][tmss_pkg::LINE_LOCK_BIT]; // see R19
	assign slot_len     = CNT_W'(SLOT_BASE_CYC + (int'(st_reg.cfg[tmss_pkg::OFS_SLOT][3:0]) - 1) * SLOT_STEP_CYC); // see R9
	assign rx_evt       = st_reg.rx_s2 != st_reg.rx_last;
	assign sync_fall    = !st_reg.ls2 && st_reg.ls3; // see R4, R5
	assign sync_rise    = st_reg.ls2 && !st_reg.ls3;
	assign first_en     = lowest_key(en_mask); // see R3
	assign next_en      = key_after(en_mask, st_reg.key); // see R21

	// Next state of the whole block.
	always_comb begin
		logic [7:0]       b_thr;
		logic [7:0]       b_conf;
		logic [7:0]       b_rec;
		logic [7:0]       b_pul;
		logic [CNT_W-1:0] blen;
		b_thr = 8'h00;
		b_conf = 8'h00;
		b_rec = 8'h00;
		b_pul = 8'h00;
		blen = '0;
		st_next = st_reg;
		st_next.load_ok = 1'b0;

		// Both pin-side inputs pass two flip-flops first.
		st_next.rx_s1 = rx_tog;
		st_next.rx_s2 = st_reg.rx_s1;
		st_next.rx_last = st_reg.rx_s2;
		st_next.ls1 = line_sync_i;
		st_next.ls2 = st_reg.ls1;
		st_next.ls3 = st_reg.ls2;

		// Command bytes and setup block loading.
		if (rx_evt) begin
			case (st_reg.mode)
				tmss_pkg::MODE_CMD: begin
					if (rx_byte == tmss_pkg::CMD_SETUP) begin
						if (st_reg.pend_setup) begin
							st_next.mode = tmss_pkg::MODE_LOAD; // see R13
							st_next.idx = 7'h00;
							st_next.crc = CRC_INIT;
							st_next.bad = 1'b0;
							st_next.pend_setup = 1'b0;
						end else begin
							st_next.pend_setup = 1'b1;
						end
					end else begin
						st_next.pend_setup = 1'b0;
					end
				end
				tmss_pkg::MODE_LOAD: begin
					if (int'(st_reg.idx) == tmss_pkg::OFS_CHECKSUM) begin
						// Last byte of the fixed block carries the checksum.
						st_next.mode = tmss_pkg::MODE_CMD; // see R14
						if (!st_reg.bad && rx_byte == st_reg.crc) begin // see R12, R22
							st_next.cfg = st_reg.shadow;
							st_next.load_ok = 1'b1;
							st_next.load_err = 1'b0;
						end else begin
							st_next.load_err = 1'b1;
						end
					end else begin
						st_next.shadow[st_reg.idx] = rx_byte;
						st_next.crc = crc8_step(st_reg.crc, rx_byte);
						st_next.idx = st_reg.idx + 7'h01;
						if (int'(st_reg.idx) >= tmss_pkg::OFS_RECAL && int'(st_reg.idx) < tmss_pkg::OFS_PULSE
							&& rx_byte == tmss_pkg::RECAL_ILLEGAL) begin
							st_next.bad = 1'b1; // see R17
						end
						if (int'(st_reg.idx) == tmss_pkg::OFS_SLOT && (int'(rx_byte[3:0]) < tmss_pkg::SLOT_MIN
							|| int'(rx_byte[3:0]) > tmss_pkg::SLOT_MAX)) begin
							st_next.bad = 1'b1; // see R9
						end
						if (int'(st_reg.idx) == tmss_pkg::OFS_FLOOR + 1
							&& int'({rx_byte, st_reg.shadow[tmss_pkg::OFS_FLOOR]}) > tmss_pkg::FLOOR_MAX) begin
							st_next.bad = 1'b1; // see R11
						end
					end
				end
				default: begin
					st_next.mode = tmss_pkg::MODE_CMD;
				end
			endcase
		end

		// Scope enables are latched per key only on its recalibration.
		for (int k = 0; k < 24; k++) begin
			if (recal_i[k]) begin
				st_next.scope_live[k] = scope_cfg[k]; // see R2
			end
		end

		// Reference checks against the floor, low byte first in the block.
		if (ref_valid_i && int'(ref_key_i) < NUM_KEYS) begin
			st_next.low_mask[ref_key_i] = ref_level_i < {st_reg.cfg[tmss_pkg::OFS_FLOOR + 1],
				st_reg.cfg[tmss_pkg::OFS_FLOOR]}; // see R10, R11
		end
		st_next.low_err = |st_next.low_mask; // see R10

		// Software clear first so that a timeout in the same cycle wins.
		if (sync_err_clear_i) begin
			st_next.sync_err = 1'b0;
		end

		// Burst scheduler on the global slot grid.
		case (st_reg.scan)
			tmss_pkg::SCAN_IDLE: begin
				if (|en_mask) begin
					st_next.scan = tmss_pkg::SCAN_BURST;
					st_next.key = first_en;
					st_next.cnt = '0;
				end
			end
			tmss_pkg::SCAN_BURST: begin
				if (st_reg.cnt >= slot_len - 1'b1) begin
					st_next.cnt = '0; // see R8
					if (next_en[5]) begin
						st_next.key = next_en[4:0]; // see R21
					end else if (!(|en_mask)) begin
						st_next.scan = tmss_pkg::SCAN_IDLE;
					end else if (line_lock_en) begin
						st_next.scan = tmss_pkg::SCAN_SYNC_WAIT; // see R3
					end else begin
						st_next.key = first_en;
					end
				end else begin
					st_next.cnt = st_reg.cnt + 1'b1;
				end
			end
			tmss_pkg::SCAN_SYNC_WAIT: begin
				if (sync_fall || st_reg.cnt >= TIMEOUT_LAST || !line_lock_en) begin
					if (!sync_fall && line_lock_en) begin
						st_next.sync_err = 1'b1; // see R7
					end
					st_next.scan = (|en_mask) ? tmss_pkg::SCAN_BURST : tmss_pkg::SCAN_IDLE; // see R3, R6
					st_next.key = first_en;
					st_next.cnt = '0;
				end else begin
					st_next.cnt = st_reg.cnt + 1'b1;
				end
			end
			default: begin
				st_next.scan = tmss_pkg::SCAN_IDLE;
			end
		endcase

		// Settings of the key whose slot runs next.
		b_thr = st_reg.cfg[tmss_pkg::OFS_THR_DRIFT + int'(st_next.key)];
		b_conf = st_reg.cfg[tmss_pkg::OFS_CONFIRM + int'(st_next.key)];
		b_rec = st_reg.cfg[tmss_pkg::OFS_RECAL + int'(st_next.key)];
		b_pul = st_reg.cfg[tmss_pkg::OFS_PULSE + int'(st_next.key)];
		blen = CNT_W'(int'(tmss_pkg::PULSE_COUNT[b_pul[5:4]]) * tmss_pkg::PULSE_CYC);
		st_next.o_burst = st_next.scan == tmss_pkg::SCAN_BURST && st_next.cnt < blen;
		st_next.o_scope = st_next.o_burst && st_next.scope_live[st_next.key]; // see R1
		st_next.o_key = st_next.key;
		st_next.o_pulses = tmss_pkg::PULSE_COUNT[b_pul[5:4]]; // see R18
		st_next.o_thr = 5'(b_thr[3:0]) + 5'(tmss_pkg::THR_OFFSET); // see R15
		st_next.o_drift = tmss_pkg::DRIFT_TENTHS[b_thr[7:4]]; // see R15
		st_next.o_supp = b_pul[tmss_pkg::SUPPRESS_BIT]; // see R18
		st_next.o_slow = b_conf[3:0]; // see R16
		st_next.o_quick = b_conf[7:4]; // see R16
		st_next.o_recal = b_rec; // see R17
		st_next.o_report = key_touch_i; // see R20
	end

	// State register.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			st_reg <= '0;
			st_reg.cfg <= tmss_pkg::CFG_RESET;
			st_reg.shadow <= tmss_pkg::CFG_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register.
	assign setup_mode_o          = st_reg.mode == tmss_pkg::MODE_LOAD;
	assign load_ok_o             = st_reg.load_ok;
	assign load_error_o          = st_reg.load_err;
	assign sync_error_o          = st_reg.sync_err;
	assign low_signal_error_o    = st_reg.low_err;
	assign burst_active_o        = st_reg.o_burst;
	assign burst_key_o           = st_reg.o_key;
	assign scope_trigger_o       = st_reg.o_scope;
	assign burst_pulses_o        = st_reg.o_pulses;
	assign burst_threshold_o     = st_reg.o_thr;
	assign burst_drift_tenths_o  = st_reg.o_drift;
	assign burst_suppress_o      = st_reg.o_supp;
	assign burst_slow_confirm_o  = st_reg.o_slow;
	assign burst_quick_confirm_o = st_reg.o_quick;
	assign burst_recal_delay_o   = st_reg.o_recal;
	assign report_y0_o           = st_reg.o_report[7:0];
	assign report_y1_o           = st_reg.o_report[15:8];
	assign report_y2_o           = st_reg.o_report[23:16];

	// ****************************************
	// Checks.
	// ****************************************
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (srst_i);

	property p_scope_in_burst; // see R1
		scope_trigger_o |-> burst_active_o && st_reg.scope_live[burst_key_o];
	endproperty
	a_scope_in_burst: assert property (p_scope_in_burst) // see R1
		else $error("Scope pulse outside an enabled burst.");

	property p_scope_needs_recal; // see R2
		(recal_i == 24'h000000) |=> $stable(st_reg.scope_live);
	endproperty
	a_scope_needs_recal: assert property (p_scope_needs_recal) // see R2
		else $error("Scope enable changed without recal.");

	property p_sync_restart_lowest; // see R3
		(st_reg.scan == tmss_pkg::SCAN_SYNC_WAIT && sync_fall && |en_mask && $stable(en_mask))
			|=> st_reg.scan == tmss_pkg::SCAN_BURST && st_reg.key == $past(first_en) && st_reg.cnt == '0;
	endproperty
	a_sync_restart_lowest: assert property (p_sync_restart_lowest) // see R3
		else $error("Sync did not restart at lowest key.");

	property p_rise_ignored; // see R4
		(st_reg.scan == tmss_pkg::SCAN_SYNC_WAIT && sync_rise && line_lock_en && st_reg.cnt < TIMEOUT_LAST)
			|=> st_reg.scan == tmss_pkg::SCAN_SYNC_WAIT;
	endproperty
	a_rise_ignored: assert property (p_rise_ignored) // see R4
		else $error("Rising sync edge ended the wait.");

	property p_timeout_flag; // see R6
		(st_reg.scan == tmss_pkg::SCAN_SYNC_WAIT && line_lock_en && !sync_fall && st_reg.cnt == TIMEOUT_LAST)
			|=> sync_error_o && st_reg.scan != tmss_pkg::SCAN_SYNC_WAIT;
	endproperty
	a_timeout_flag: assert property (p_timeout_flag) // see R6, R7
		else $error("Sync timeout not flagged.");

	property p_slot_bound; // see R8
		st_reg.scan == tmss_pkg::SCAN_BURST && $stable(slot_len) |-> st_reg.cnt < slot_len;
	endproperty
	a_slot_bound: assert property (p_slot_bound) // see R8
		else $error("Burst slot overran its interval.");

	property p_slot_default; // see R9
		$fell(srst_i) |-> slot_len == CNT_W'(SLOT_BASE_CYC);
	endproperty
	a_slot_default: assert property (p_slot_default) // see R9
		else $error("Default slot interval wrong.");

	property p_low_signal; // see R10
		(ref_valid_i && int'(ref_key_i) < NUM_KEYS && ref_level_i < {st_reg.cfg[tmss_pkg::OFS_FLOOR + 1],
			st_reg.cfg[tmss_pkg::OFS_FLOOR]}) |=> low_signal_error_o;
	endproperty
	a_low_signal: assert property (p_low_signal) // see R10
		else $error("Low reference not flagged.");

	property p_load_from_setup; // see R13
		load_ok_o |-> $past(st_reg.mode) == tmss_pkg::MODE_LOAD && st_reg.mode == tmss_pkg::MODE_CMD;
	endproperty
	a_load_from_setup: assert property (p_load_from_setup) // see R13
		else $error("Block accepted outside setup mode.");

	property p_no_disabled_slot; // see R21
		(st_reg.scan == tmss_pkg::SCAN_BURST && st_reg.cnt == '0 && $stable(en_mask)) |-> en_mask[st_reg.key];
	endproperty
	a_no_disabled_slot: assert property (p_no_disabled_slot) // see R21
		else $error("Disabled key got a slot.");

	property p_report_order; // see R20
		##1 report_y1_o == $past(key_touch_i[15:8]);
	endproperty
	a_report_order: assert property (p_report_order) // see R20
		else $error("Report byte order wrong.");
endmodule

/* File: tmss_host.sv */
`timescale 1ns/1ns

// ****************************************
// Host model driving the serial setup link.
// ****************************************
module tmss_host (
	// Link pins.
	output logic spi_sck_o,
	output logic spi_ss_n_o,
	output logic spi_mosi_o
);
	logic [7:0] blk [100];
	logic [7:0] crc;

	// The link clock is parked low and the frame deselected between bytes.
	initial begin
		spi_sck_o = 1'b0;
		spi_ss_n_o = 1'b1;
		spi_mosi_o = 1'b1;
	end

	// One byte per frame, MSB first, 125 ns link period; data is scrambled once deselected.
	task automatic send_byte(input logic [7:0] b);
		spi_ss_n_o = 1'b0;
		#400;
		for (int i = 7; i >= 0; i--) begin
			spi_mosi_o = b[i];
			#62 spi_sck_o = 1'b1;
			#63 spi_sck_o = 1'b0;
		end
		#100 spi_ss_n_o = 1'b1;
		spi_mosi_o = ~b[0];
		#1000;
	endtask

	// Enters setup mode and sends the block; bad inverts the checksum.
	task automatic send_block(input logic bad);
		crc = 8'h00;
		send_byte(8'h01);
		send_byte(8'h01);
		for (int i = 0; i < 100; i++) begin
			send_byte(blk[i]);
			crc = crc ^ blk[i];
			for (int j = 0; j < 8; j++)
				crc = crc[7] ? ({crc[6:0], 1'b0} ^ 8'h07) : {crc[6:0], 1'b0};
		end
		send_byte(bad ? ~crc : crc);
	endtask
endmodule

/* File: tmss_top_bench.sv */
`timescale 1ns/1ns

// ****************************************
// Self-checking bench for the setup loader and scheduler.
// ****************************************
module tmss_top_bench;
	localparam int SB = 3000;
	localparam int ST = 25;
	localparam int TO = 200;
	logic clk_sys_i, srst_i, line_sync_i, ref_valid_i, sync_err_clear_i, sck, ss_n, mosi;
	logic [4:0] ref_key_i, burst_key_o, thr;
	logic [15:0] ref_level_i;
	logic [23:0] recal_i, key_touch_i;
	logic setup_mode_o, load_ok_o, load_error_o, sync_error_o, low_err, burst_active_o, scope;
	logic [6:0] pulses;
	logic [7:0] y0, y1, y2;
	int error_cnt, cmp_count, cyc, n, ok_seen, setup_seen;

	tmss_host u_tmss_host (.spi_sck_o(sck), .spi_ss_n_o(ss_n), .spi_mosi_o(mosi));

	tmss_top #(.SLOT_BASE_CYC(SB), .SLOT_STEP_CYC(ST), .SYNC_TIMEOUT_CYC(TO)) u_tmss_top (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .spi_sck_i(sck), .spi_ss_n_i(ss_n), .spi_mosi_i(mosi),
		.line_sync_i(line_sync_i), .ref_valid_i(ref_valid_i), .ref_key_i(ref_key_i),
		.ref_level_i(ref_level_i), .recal_i(recal_i), .key_touch_i(key_touch_i),
		.sync_err_clear_i(sync_err_clear_i), .setup_mode_o(setup_mode_o), .load_ok_o(load_ok_o),
		.load_error_o(load_error_o), .sync_error_o(sync_error_o), .low_signal_error_o(low_err),
		.burst_active_o(burst_active_o), .burst_key_o(burst_key_o), .scope_trigger_o(scope),
		.burst_pulses_o(pulses), .burst_threshold_o(thr), .burst_drift_tenths_o(),
		.burst_suppress_o(), .burst_slow_confirm_o(), .burst_quick_confirm_o(),
		.burst_recal_delay_o(), .report_y0_o(y0), .report_y1_o(y1), .report_y2_o(y2));

	// Clock generation.
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// Cycle counter that cuts a hang short.
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			test_done();
		end
	end

	// Counts the one-cycle accept pulses and the setup mode cycles between clock edges.
	always @(negedge clk_sys_i) begin
		if (load_ok_o === 1'b1)
			ok_seen++;
		if (setup_mode_o === 1'b1)
			setup_seen++;
	end

	// Compares a seen value with the expected one.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Waits for a fresh burst of key k and returns the cycles spent.
	task automatic wait_burst(input logic [4:0] k, output int cnt);
		logic prev;
		prev = 1'b1;
		cnt = 0;
		while (!(burst_active_o === 1'b1 && !prev && burst_key_o === k) && cnt < 9000) begin
			prev = burst_active_o;
			@(posedge clk_sys_i);
			#1;
			cnt++;
		end
	endtask

	// Reports a reference level and checks the low signal flag.
	task automatic ref_check(input logic [15:0] lvl, input logic exp);
		@(posedge clk_sys_i);
		ref_valid_i <= 1'b1;
		ref_key_i <= 5'h03;
		ref_level_i <= lvl;
		@(posedge clk_sys_i);
		ref_valid_i <= 1'b0;
		@(posedge clk_sys_i);
		#1;
		check(low_err, exp);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("errors=%0d compares=%0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// The first edge after reset opens the key 0 slot with default settings.
	task automatic t_defaults();
		@(posedge clk_sys_i);
		#1;
		check({burst_active_o, burst_key_o, thr, pulses}, {1'b1, 5'h00, 5'h0a, 7'h30});
	endtask

	// Touch states come back one cycle later, one byte per Y line.
	task automatic t_report();
		@(posedge clk_sys_i);
		key_touch_i <= 24'h804201;
		repeat (2) @(posedge clk_sys_i);
		#1;
		check({y2, y1, y0}, 24'h804201);
	endtask

	// A good block is taken once through setup mode; its floor is low byte first.
	task automatic t_load();
		for (int i = 0; i < 24; i++) begin
			u_tmss_host.blk[i] = 8'ha6;
			u_tmss_host.blk[24 + i] = (i == 1 || i == 2) ? 8'h52 : 8'h50;
			u_tmss_host.blk[48 + i] = 8'h14;
			u_tmss_host.blk[72 + i] = (i == 1) ? 8'h80 : 8'h00;
		end
		{u_tmss_host.blk[96], u_tmss_host.blk[97], u_tmss_host.blk[98], u_tmss_host.blk[99]} = 32'h4002c800;
		u_tmss_host.send_block(1'b0);
		repeat (10) @(posedge clk_sys_i);
		#1;
		check(ok_seen, 1);
		check({setup_mode_o, load_error_o, setup_seen > 2400}, 3'b001);
		ref_check(16'h0096, 1'b1);
		ref_check(16'h00c8, 1'b0);
	endtask

	// Only keys 1 and 2 get slots; with no sync edge the wait runs to its timeout.
	task automatic t_scan();
		wait_burst(5'h01, n);
		check({scope, pulses}, {1'b0, 7'h10});
		wait_burst(5'h02, n);
		check(n, SB + ST);
		wait_burst(5'h01, n);
		check(n, SB + ST + TO);
		check(sync_error_o, 1'b1);
		@(posedge clk_sys_i);
		sync_err_clear_i <= 1'b1;
		recal_i <= 24'h000002;
		@(posedge clk_sys_i);
		sync_err_clear_i <= 1'b0;
		recal_i <= 24'h0;
		@(posedge clk_sys_i);
		#1;
		check(sync_error_o, 1'b0);
	endtask

	// A rising sync edge is ignored; a falling one restarts key 1 with its scope pulse.
	task automatic t_sync();
		wait_burst(5'h02, n);
		repeat (SB + 50) @(posedge clk_sys_i);
		line_sync_i <= 1'b1;
		repeat (20) @(posedge clk_sys_i);
		#1;
		check(burst_active_o, 1'b0);
		@(posedge clk_sys_i);
		line_sync_i <= 1'b0;
		#1;
		wait_burst(5'h01, n);
		check({sync_error_o, n < 10, scope}, 3'b011);
		n = 0;
		while (scope === 1'b1 && n < 5000) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		check(n, 16 * 44);
	endtask

	// A bad checksum and then an illegal recal delay are both refused.
	task automatic t_reject();
		u_tmss_host.send_block(1'b1);
		repeat (20) @(posedge clk_sys_i);
		#1;
		check({load_error_o, setup_mode_o}, 2'b10);
		u_tmss_host.blk[48] = 8'hff;
		u_tmss_host.send_block(1'b0);
		repeat (20) @(posedge clk_sys_i);
		#1;
		check(load_error_o, 1'b1);
		check(ok_seen, 1);
	endtask

	// Main sequence.
	initial begin
		{line_sync_i, ref_valid_i, sync_err_clear_i, ref_key_i, ref_level_i, recal_i} = '0;
		key_touch_i = 24'h0;
		srst_i = 1'b1;
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		t_defaults();
		t_report();
		ref_check(16'h0063, 1'b1);
		ref_check(16'h0064, 1'b0);
		t_load();
		t_scan();
		t_sync();
		t_reject();
		test_done();
	end
endmodule
